//--- rtl/cid_pkg.sv
// Constants for the register/memory and multiply instruction decoder
package cid_pkg;
  // Opcode high nibble selects the addressing mode
  localparam logic [3:0] MODE_IMM = 4'ha;
  localparam logic [3:0] MODE_DIR = 4'hb;
  localparam logic [3:0] MODE_EXT = 4'hc;
  localparam logic [3:0] MODE_IX2 = 4'hd;
  localparam logic [3:0] MODE_IX1 = 4'he;
  localparam logic [3:0] MODE_IX  = 4'hf;
  // Opcode low nibble selects the function
  localparam logic [3:0] FN_SUB = 4'h0;
  localparam logic [3:0] COMPARE_ACCUMULATOR_OP  = 4'h1;
  localparam logic [3:0] SUBTRACT_WITH_BORROW_OP = 4'h2;
  localparam logic [3:0] COMPARE_INDEX_OP        = 4'h3;
  localparam logic [3:0] FN_AND = 4'h4;
  localparam logic [3:0] FN_BIT = 4'h5;
  localparam logic [3:0] LOAD_ACCUMULATOR_OP  = 4'h6;
  localparam logic [3:0] STORE_ACCUMULATOR_OP = 4'h7;
  localparam logic [3:0] EXCLUSIVE_OR_OP      = 4'h8;
  localparam logic [3:0] FN_ADC = 4'h9;
  localparam logic [3:0] FN_ORA = 4'ha;
  localparam logic [3:0] FN_ADD = 4'hb;
  localparam logic [3:0] JUMP_UNCONDITIONAL_OP = 4'hc;
  localparam logic [3:0] CALL_SUBROUTINE_OP    = 4'hd;
  localparam logic [3:0] FN_LDX = 4'he;
  localparam logic [3:0] FN_STX = 4'hf;
  localparam logic [7:0] UNSIGNED_PRODUCT_OP = 8'h42;
  // Lengths in bytes and base cycle counts per mode
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  localparam logic [3:0] CYC_IMM = 4'h2;
  localparam logic [3:0] CYC_DIR = 4'h3;
  localparam logic [3:0] CYC_EXT = 4'h4;
  localparam logic [3:0] CYC_IX  = 4'h3;
  localparam logic [3:0] CYC_IX1 = 4'h4;
  localparam logic [3:0] CYC_IX2 = 4'h5;
  localparam logic [3:0] CYC_PRODUCT = 4'hb;
  localparam logic [3:0] CYC_ONE = 4'h1;
  localparam logic [3:0] CYC_CALL_EXTRA = 4'h2;
  localparam logic [3:0] CYC_JUMP_LESS  = 4'h1;
  // Condition code bit positions and reset values
  localparam int CC_C = 0;
  localparam int CC_Z = 1;
  localparam int CC_N = 2;
  localparam int CC_I = 3;
  localparam int CC_H = 4;
  localparam int HALF_BIT = 4;
  localparam logic [4:0] CC_RESET = 5'h08;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

//--- rtl/cid_core.sv
// Execute stage for multiply and the register/memory instruction group
`timescale 1ns/10ps

// Summary of operation
// - Multiply index by accumulator; high byte to index, low byte to A.
// - Multiply is one byte, eleven cycles, clears H and C only.
// - Add-with-carry adds operand and carry into accumulator, low nibble 9.
// - Subtract-with-borrow subtracts operand and carry; sets N, Z, C.
// - Exclusive-or into accumulator; sets N, Z; keeps C and H.
// - Accumulator compare subtracts for flags only; accumulator unchanged.
// - Index compare subtracts operand from index for N, Z, C only.
// - Bit test ANDs accumulator and operand for flags, result discarded.
// - Half carry is the carry from bit 3 into bit 4.
// - Tested flags follow the result; untouched flags keep their value.
module cid_core
  import cid_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       op_valid,
  input  wire logic [7:0] op_code,
  input  wire logic [7:0] op_operand,
  output logic            op_ready,
  output logic            op_done,
  output logic            op_illegal,
  output logic [1:0]      op_length,
  output logic [3:0]      op_cycles,
  output logic            op_store,
  output logic [7:0]      store_data,
  output logic [7:0]      acc_out,
  output logic [7:0]      idx_out,
  output logic [4:0]      ccr_out
);

  default clocking cid_cb @(posedge sys_clk);
  endclocking
  default disable iff (srst);

  typedef enum logic [1:0] {
    CID_IDLE = 2'b00,
    CID_BUSY = 2'b01,
    CID_DONE = 2'b10
  } cid_state_e;

  cid_state_e  state_q, state_d;
  logic [7:0]  acc_q, acc_d;
  logic [7:0]  idx_q, idx_d;
  logic [4:0]  ccr_q, ccr_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [1:0]  len_q, len_d;
  logic [3:0]  cyc_q, cyc_d;
  logic        ill_q, ill_d;
  logic        st_q, st_d;
  logic [7:0]  sd_q, sd_d;

  logic [3:0]  hi;
  logic [3:0]  lo;
  logic        is_product;
  logic        legal;
  logic [1:0]  len_dec;
  logic [3:0]  cyc_dec;
  logic [15:0] product;
  logic [8:0]  sum9;
  logic [4:0]  half5;
  logic [8:0]  diff9;
  logic [7:0]  res8;
  logic [7:0]  sub_lhs;
  logic        cin;

  assign hi      = op_code[7:4];
  assign lo      = op_code[3:0];
  assign is_product = (op_code == UNSIGNED_PRODUCT_OP);
  assign cin     = ccr_q[CC_C];
  assign product = acc_q * idx_q;
  // Stores and jumps have no immediate form
  assign legal = is_product || (hi >= MODE_IMM &&
                 !(hi == MODE_IMM &&
                   (lo == STORE_ACCUMULATOR_OP || lo == FN_STX ||
                    lo == JUMP_UNCONDITIONAL_OP ||
                    lo == CALL_SUBROUTINE_OP)));

  // Length and cycle decode
  always_comb begin
    len_dec = LEN_1;
    cyc_dec = CYC_ONE;
    if (is_product) begin
      len_dec = LEN_1;
      cyc_dec = CYC_PRODUCT;
    end else begin
      case (hi)
        MODE_IMM: begin
          len_dec = LEN_2;
          cyc_dec = CYC_IMM;
        end
        MODE_DIR: begin
          len_dec = LEN_2;
          cyc_dec = CYC_DIR;
        end
        MODE_EXT: begin
          len_dec = LEN_3;
          cyc_dec = CYC_EXT;
        end
        MODE_IX: begin
          len_dec = LEN_1;
          cyc_dec = CYC_IX;
        end
        MODE_IX1: begin
          len_dec = LEN_2;
          cyc_dec = CYC_IX1;
        end
        MODE_IX2: begin
          len_dec = LEN_3;
          cyc_dec = CYC_IX2;
        end
        default: ;
      endcase
      if (lo == STORE_ACCUMULATOR_OP || lo == FN_STX)
        cyc_dec = cyc_dec + CYC_ONE;
      else if (lo == JUMP_UNCONDITIONAL_OP)
        cyc_dec = cyc_dec - CYC_JUMP_LESS;
      else if (lo == CALL_SUBROUTINE_OP)
        cyc_dec = cyc_dec + CYC_CALL_EXTRA;
    end
    // A refused opcode must not borrow the timing of its nibbles
    if (!legal) begin
      len_dec = LEN_1;
      cyc_dec = CYC_ONE;
    end
  end

  // Arithmetic
  always_comb begin
    sub_lhs = (lo == COMPARE_INDEX_OP) ? idx_q : acc_q;
    sum9  = {1'b0, acc_q} + {1'b0, op_operand} +
            {8'h00, (lo == FN_ADC) ? cin : 1'b0};
    half5 = {1'b0, acc_q[3:0]} + {1'b0, op_operand[3:0]} +
            {4'h0, (lo == FN_ADC) ? cin : 1'b0};
    diff9 = {1'b0, sub_lhs} - {1'b0, op_operand} -
            {8'h00, (lo == SUBTRACT_WITH_BORROW_OP) ? cin : 1'b0};
  end

  // Execute
  always_comb begin
    state_d = state_q;
    acc_d   = acc_q;
    idx_d   = idx_q;
    ccr_d   = ccr_q;
    cnt_d   = cnt_q;
    len_d   = len_q;
    cyc_d   = cyc_q;
    ill_d   = ill_q;
    st_d    = 1'b0;
    sd_d    = sd_q;
    res8    = BYTE_ZERO;
    case (state_q)
      CID_IDLE: begin
        if (op_valid) begin
          len_d   = len_dec;
          cyc_d   = cyc_dec;
          ill_d   = !legal;
          cnt_d   = cyc_dec - CYC_ONE;
          state_d = (cyc_dec > CYC_ONE) ? CID_BUSY : CID_DONE;
          if (legal && is_product) begin
            idx_d = product[15:8];
            acc_d = product[7:0];
            ccr_d[CC_H] = 1'b0;
            ccr_d[CC_C] = 1'b0;
          end else if (legal) begin
            case (lo)
              FN_ADD, FN_ADC: begin
                acc_d = sum9[7:0];
                ccr_d[CC_H] = half5[HALF_BIT];
                ccr_d[CC_C] = sum9[8];
                ccr_d[CC_N] = sum9[7];
                ccr_d[CC_Z] = (sum9[7:0] == BYTE_ZERO);
              end
              FN_SUB, SUBTRACT_WITH_BORROW_OP, COMPARE_ACCUMULATOR_OP,
              COMPARE_INDEX_OP: begin
                if (lo == FN_SUB || lo == SUBTRACT_WITH_BORROW_OP)
                  acc_d = diff9[7:0];
                ccr_d[CC_C] = diff9[8];
                ccr_d[CC_N] = diff9[7];
                ccr_d[CC_Z] = (diff9[7:0] == BYTE_ZERO);
              end
              FN_AND, FN_BIT, FN_ORA, EXCLUSIVE_OR_OP, LOAD_ACCUMULATOR_OP,
              FN_LDX: begin
                case (lo)
                  FN_ORA:  res8 = acc_q | op_operand;
                  EXCLUSIVE_OR_OP: res8 = acc_q ^ op_operand;
                  LOAD_ACCUMULATOR_OP,
                  FN_LDX:  res8 = op_operand;
                  default: res8 = acc_q & op_operand;
                endcase
                if (lo == FN_LDX)
                  idx_d = res8;
                else if (lo != FN_BIT)
                  acc_d = res8;
                ccr_d[CC_N] = res8[7];
                ccr_d[CC_Z] = (res8 == BYTE_ZERO);
              end
              STORE_ACCUMULATOR_OP, FN_STX: begin
                sd_d = (lo == FN_STX) ? idx_q : acc_q;
                st_d = 1'b1;
                ccr_d[CC_N] = sd_d[7];
                ccr_d[CC_Z] = (sd_d == BYTE_ZERO);
              end
              default: ;  // Jumps change no flags
            endcase
          end
        end
      end
      CID_BUSY: begin
        cnt_d = cnt_q - CYC_ONE;
        if (cnt_q == CYC_ONE)
          state_d = CID_DONE;
      end
      CID_DONE: state_d = CID_IDLE;
      default:  state_d = CID_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= CID_IDLE;
      acc_q   <= BYTE_ZERO;
      idx_q   <= BYTE_ZERO;
      ccr_q   <= CC_RESET;
      cnt_q   <= 4'h0;
      len_q   <= 2'h0;
      cyc_q   <= 4'h0;
      ill_q   <= 1'b0;
      st_q    <= 1'b0;
      sd_q    <= BYTE_ZERO;
    end else begin
      state_q <= state_d;
      acc_q   <= acc_d;
      idx_q   <= idx_d;
      ccr_q   <= ccr_d;
      cnt_q   <= cnt_d;
      len_q   <= len_d;
      cyc_q   <= cyc_d;
      ill_q   <= ill_d;
      st_q    <= st_d;
      sd_q    <= sd_d;
    end
  end

  // Ready and done registered so every output leaves a flip-flop
  logic rdy_q, done_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rdy_q  <= 1'b1;
      done_q <= 1'b0;
    end else begin
      rdy_q  <= (state_d == CID_IDLE);
      done_q <= (state_d == CID_DONE);
    end
  end

  assign op_ready   = rdy_q;
  assign op_done    = done_q;
  assign op_illegal = ill_q;
  assign op_length  = len_q;
  assign op_cycles  = cyc_q;
  assign op_store   = st_q;
  assign store_data = sd_q;
  assign acc_out    = acc_q;
  assign idx_out    = idx_q;
  assign ccr_out    = ccr_q;

  // Checks
  logic take;
  assign take = op_valid && rdy_q && legal;

  a_product_value: assert property (take && is_product |=>
    {idx_q, acc_q} == $past(acc_q) * $past(idx_q))
    else $error("multiply product wrong");
  a_product_flags: assert property (take && is_product |=>
    !ccr_q[CC_H] && !ccr_q[CC_C] && ccr_q[CC_N] == $past(ccr_q[CC_N]) &&
    ccr_q[CC_Z] == $past(ccr_q[CC_Z]))
    else $error("multiply flags wrong");
  a_product_cycles: assert property (take && is_product |=>
    !op_done [*5] ##1 !op_done [*5] ##1 op_done)
    else $error("multiply not eleven cycles");
  a_adc_sum: assert property (
    take && op_code == {MODE_IMM, FN_ADC} |=>
    acc_q == 8'($past(acc_q) + $past(op_operand) + $past(ccr_q[CC_C])))
    else $error("add with carry wrong");
  a_borrow_diff: assert property (
    take && !is_product && lo == SUBTRACT_WITH_BORROW_OP |=>
    acc_q == 8'($past(acc_q) - $past(op_operand) - $past(ccr_q[CC_C])))
    else $error("subtract with borrow wrong");
  a_xor_keep: assert property (
    take && !is_product && lo == EXCLUSIVE_OR_OP |=>
    acc_q == ($past(acc_q) ^ $past(op_operand)) &&
    ccr_q[CC_C] == $past(ccr_q[CC_C]))
    else $error("exclusive or wrong");
  a_compare_keep: assert property (
    take && !is_product &&
    (lo == COMPARE_ACCUMULATOR_OP || lo == FN_BIT) |=> $stable(acc_q))
    else $error("compare altered accumulator");
  a_index_compare: assert property (
    take && !is_product && lo == COMPARE_INDEX_OP |=>
    ccr_q[CC_C] == ($past(idx_q) < $past(op_operand)) && $stable(idx_q))
    else $error("index compare wrong");
  a_half_carry: assert property (
    take && !is_product && lo == FN_ADD |=> ccr_q[CC_H] ==
    (5'($past(acc_q[3:0]) + $past(op_operand[3:0])) > 5'h0f))
    else $error("half carry wrong");
  a_len_decode: assert property (take && hi == MODE_IX |=>
    op_length == LEN_1)
    else $error("indexed length wrong");
  a_store_cycles: assert property (
    take && hi == MODE_DIR && lo == STORE_ACCUMULATOR_OP |=>
    op_cycles == 4'h4)
    else $error("store cycles wrong");
  a_refused_one: assert property (
    op_valid && rdy_q && !legal |=> op_done && op_illegal &&
    op_cycles == 4'h1)
    else $error("refused opcode not one cycle");

  c_product: cover property (@(posedge sys_clk) take && is_product);
  c_adc_half: cover property (@(posedge sys_clk)
    take && lo == FN_ADC ##1 ccr_q[CC_H]);
  c_store: cover property (@(posedge sys_clk) op_store);
  c_illegal: cover property (@(posedge sys_clk) op_done && op_illegal);

endmodule

//--- sim/cid_mem_model.sv
// Data memory behind the decoder: serves operands, takes stored bytes
`timescale 1ns/10ps
module cid_mem_model (
  input  wire logic       sys_clk,
  input  wire logic       rd_en,
  input  wire logic [7:0] addr,
  input  wire logic       wr_en,
  input  wire logic [7:0] wr_data,
  output logic [7:0]      rd_data
);
  logic [7:0] mem [256];
  logic [7:0] last_q;

  // Each byte holds its own address, so an operand value is its address
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = i[7:0];
    last_q = 8'h00;
  end

  // A released bus shows the inverse of the last byte, never a stale copy
  always_comb rd_data = rd_en ? mem[addr] : ~last_q;

  // Plain always: the array is also preset by the initial block
  always @(posedge sys_clk) begin
    if (rd_en) last_q <= mem[addr];
    if (wr_en) mem[addr] <= wr_data;
  end
endmodule

//--- sim/tb.sv
// Self-checking bench for the multiply and register/memory decoder
`timescale 1ns/10ps
module tb;
  import cid_pkg::*;
  logic       sys_clk, srst, op_valid, op_ready, op_done, op_illegal;
  logic       op_store;
  logic [7:0] op_code, op_operand, store_data, acc_out, idx_out, addr;
  logic [1:0] op_length;
  logic [3:0] op_cycles;
  logic [4:0] ccr_out;
  int         errors, checked;

  cid_core dut (.sys_clk(sys_clk), .srst(srst), .op_valid(op_valid),
    .op_code(op_code), .op_operand(op_operand), .op_ready(op_ready),
    .op_done(op_done), .op_illegal(op_illegal), .op_length(op_length),
    .op_cycles(op_cycles), .op_store(op_store), .store_data(store_data),
    .acc_out(acc_out), .idx_out(idx_out), .ccr_out(ccr_out));
  cid_mem_model dm (.sys_clk(sys_clk), .rd_en(op_valid), .addr(addr),
    .wr_en(op_store), .wr_data(store_data), .rd_data(op_operand));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      errors++;
    end
  endtask

  task automatic close_out();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Issue one instruction, operand byte = address; len 0 skips size checks
  task automatic go(input logic [7:0] op, input logic [7:0] adr,
                    input logic [1:0] len, input logic [3:0] cyc);
    int n;
    logic st;
    st = (op[2:0] == 3'h7) && (op[7:4] > MODE_IMM);
    @(negedge sys_clk);
    op_valid = 1'b1;
    op_code  = op;
    addr     = adr;
    n = 0;
    while (op_ready !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    @(negedge sys_clk);
    op_valid = 1'b0;
    chk(op_store, st, "store pulse");
    if (st) chk(store_data, acc_out, "store data");
    n = 1;
    while (op_done !== 1'b1 && n < 20) begin
      @(negedge sys_clk);
      n++;
    end
    chk(n, cyc, "done timing");
    if (len != 2'h0) begin
      chk(op_length, len, "length");
      chk(op_cycles, cyc, "cycles");
      chk(op_illegal, 1'b0, "legal");
    end
  endtask

  task automatic t_reset();
    chk(op_ready, 1'b1, "ready after reset");
    chk({idx_out, acc_out}, 16'h0000, "regs after reset");
    chk(ccr_out, CC_RESET, "flags after reset");
  endtask

  // Every mode of add-with-carry; store, jump and call in every mode but immediate
  task automatic t_modes();
    logic [1:0] lens [6];
    logic [3:0] cycs [6];
    logic [3:0] m;
    lens = '{LEN_2, LEN_2, LEN_3, LEN_3, LEN_2, LEN_1};
    cycs = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h4, 4'h3};
    for (int i = 0; i < 6; i++) begin
      m = MODE_IMM + i[3:0];
      go({m, FN_ADC}, 8'h00, lens[i], cycs[i]);
      if (i > 0) begin
        // Stores land on a byte that no later operand reads
        go({m, STORE_ACCUMULATOR_OP}, 8'hf0, lens[i],
           cycs[i] + 4'h1);
        go({m, JUMP_UNCONDITIONAL_OP}, 8'h00, lens[i],
           cycs[i] - 4'h1);
        go({m, CALL_SUBROUTINE_OP}, 8'h00, lens[i],
           cycs[i] + 4'h2);
      end
    end
    go({MODE_IMM, STORE_ACCUMULATOR_OP}, 8'h00, 2'h0, 4'h1);
    chk(op_illegal, 1'b1, "store immediate refused");
  endtask

  task automatic t_mul();
    go(8'ha6, 8'h8f, LEN_2, 4'h2);
    go(8'hab, 8'h81, LEN_2, 4'h2);
    chk({acc_out, 3'h0, ccr_out}, 16'h1019, "add carries");
    go(8'ha6, 8'h34, LEN_2, 4'h2);
    go(8'hb7, 8'h40, LEN_2, 4'h4);
    chk(dm.mem[8'h40], 8'h34, "stored byte");
    go(8'hae, 8'h80, LEN_2, 4'h2);
    go(UNSIGNED_PRODUCT_OP, 8'h00, LEN_1, 4'hb);
    chk({idx_out, acc_out}, 16'h1a00, "product");
    chk(ccr_out, 5'h0c, "multiply flags");
  endtask

  // Each line: opcode, operand, expected {acc, idx}, expected flags
  task automatic t_arith();
    logic [7:0]  ops [8];
    logic [7:0]  opd [8];
    logic [15:0] res [8];
    logic [4:0]  ccs [8];
    ops = '{8'ha6, 8'ha9, 8'hb2, 8'ha1, 8'ha2, 8'ha8, 8'ha3, 8'ha5};
    opd = '{8'h0f, 8'h01, 8'h10, 8'h20, 8'h00, 8'hff, 8'h1b, 8'h0f};
    res = '{16'h0f1a, 16'h101a, 16'h001a, 16'h001a, 16'hff1a, 16'h001a,
            16'h001a, 16'h001a};
    ccs = '{5'h08, 5'h18, 5'h1a, 5'h1d, 5'h1d, 5'h1b, 5'h1d, 5'h1b};
    for (int i = 0; i < 8; i++) begin
      go(ops[i], opd[i], LEN_2,
         (ops[i][7:4] == MODE_DIR) ? CYC_DIR : CYC_IMM);
      chk({acc_out, idx_out}, res[i], "registers");
      chk(ccr_out, ccs[i], "flags");
    end
  endtask

  initial begin
    #(4 * 3000);
    errors++;
    close_out();
  end

  initial begin
    errors = 0;
    checked = 0;
    srst = 1'b1;
    op_valid = 1'b0;
    op_code = 8'h00;
    addr = 8'h00;
    repeat (12) @(negedge sys_clk);
    srst = 1'b0;
    t_reset();
    t_modes();
    t_mul();
    t_arith();
    close_out();
  end
endmodule
